// File: inc/readback_defines.vh
// Constants for the configuration readback CRC serializer
`ifndef READBACK_DEFINES_VH
`define READBACK_DEFINES_VH
`define RB_CRC_POLY 16'h1021
`define RB_CRC_SEED 16'h0000
`define RB_CRC_OUT_BITS 11
`define RB_CHECK_BITS 4
`define RB_DUMMY_BITS 5
`define RB_FIRST_ONES 2
`define RB_LAST_ONES 7
`define RB_CHECK_PATTERN 4'hA
`endif

// File: design/config_readback_crc_serializer.v
// Configuration load frame checker and readback CRC serializer
`timescale 1ns/1ns
`include "readback_defines.vh"
module config_readback_crc_serializer #(
   parameter FRAME_BITS = 266,
   parameter NUM_FRAMES = 932,
   parameter CNT_W = 16
) (
   // Clock and reset
   input wire i_clk,
   input wire i_resetn,
   // Configuration load stream
   input wire i_cfg_bit_valid,
   input wire i_cfg_bit,
   input wire i_cfg_done,
   output reg o_cfg_error_n,
   output reg o_cfg_wait,
   // Configuration memory read port
   output reg o_mem_rd,
   output reg [CNT_W-1:0] o_mem_frame,
   output reg [CNT_W-1:0] o_mem_bit,
   input wire i_mem_data,
   // Live state capture
   input wire i_capture_en,
   input wire i_state_data,
   // Readback nets
   input wire i_readback_trigger,
   input wire i_readback_shift_clock,
   output reg o_read_in_progress,
   output reg o_readback_serial_out
);
   // States
   localparam S_IDLE = 3'd0;
   localparam S_DUMMY = 3'd1;
   localparam S_FRAME = 3'd2;
   localparam S_END = 3'd3;
   localparam S_CRC = 3'd4;
   localparam S_FIN = 3'd5;

   // Stream positions, worked out wide and cut to the counter width
   localparam integer LAST_BIT_I = FRAME_BITS - 1;
   localparam integer LAST_FRAME_I = NUM_FRAMES - 1;
   localparam integer CHK_START_I = FRAME_BITS - `RB_CHECK_BITS;
   localparam integer ONES_START_I = FRAME_BITS - `RB_LAST_ONES;
   localparam integer FIRST_ONES_I = `RB_FIRST_ONES;
   localparam integer DUMMY_LAST_I = `RB_DUMMY_BITS - 1;
   localparam integer CRC_LAST_I = `RB_CRC_OUT_BITS - 1;
   localparam [CNT_W-1:0] LAST_BIT = LAST_BIT_I[CNT_W-1:0];
   localparam [CNT_W-1:0] LAST_FRAME = LAST_FRAME_I[CNT_W-1:0];
   localparam [CNT_W-1:0] CHK_START = CHK_START_I[CNT_W-1:0];
   localparam [CNT_W-1:0] ONES_START = ONES_START_I[CNT_W-1:0];
   localparam [CNT_W-1:0] FIRST_ONES = FIRST_ONES_I[CNT_W-1:0];
   localparam [3:0] DUMMY_LAST = DUMMY_LAST_I[3:0];
   localparam [3:0] CRC_LAST = CRC_LAST_I[3:0];
   localparam [3:0] CHECK_PATTERN = `RB_CHECK_PATTERN;
   localparam [15:0] CRC_POLY = `RB_CRC_POLY;
   // Far-side inputs through the synchronisers: trigger, shift clock
   localparam integer SYNC_N = 2;

   // Synchronised far-side inputs
   reg clk_last_q;
   wire trig_sync;
   wire clk_sync;

   // Readback sequencer state
   reg [2:0] state_q;
   reg [CNT_W-1:0] frame_q;
   reg [CNT_W-1:0] bit_q;
   reg [3:0] cnt_q;
   reg [15:0] crc_q;

   // Load checker state
   reg [CNT_W-1:0] ld_bit_q;
   reg [3:0] ld_chk_q;
   reg ld_par_q;

   // Edge strobe and combinational output pick
   wire rise;
   reg out_d;
   reg adv_crc;

   // Far-side inputs gathered for the synchronisers
   wire [SYNC_N-1:0] async_in;
   wire [SYNC_N-1:0] sync_vec;
   assign async_in = {i_readback_shift_clock, i_readback_trigger};

   // Two flops per far-side input before any logic reads it
   genvar s;
   generate
      for (s = 0; s < SYNC_N; s = s + 1) begin : g_sync
         reg meta_q;
         reg sync_q;
         always @(posedge i_clk) begin
            if (!i_resetn) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= async_in[s];
               sync_q <= meta_q;
            end
         end
         assign sync_vec[s] = sync_q;
      end
   endgenerate

   // Named views of the synchronised inputs
   assign trig_sync = sync_vec[0];
   assign clk_sync = sync_vec[1];

   // Last shift clock level, idles low like the pin: no false edge
   always @(posedge i_clk) begin
      if (!i_resetn)
         clk_last_q <= 1'b0;
      else
         clk_last_q <= clk_sync;
   end

   // Shift clock rising edge
   assign rise = clk_sync & ~clk_last_q;

   // Load position flags within the incoming frame
   wire ld_last;
   wire ld_in_check;
   wire ld_in_data;
   assign ld_last = (ld_bit_q == LAST_BIT);
   assign ld_in_check = (ld_bit_q >= CHK_START);
   assign ld_in_data = (ld_bit_q != {CNT_W{1'b0}});

   // expected check nibble, 101 then running parity
   wire [3:0] chk_seen;
   wire [3:0] chk_want;
   wire frame_bad;
   assign chk_seen = {ld_chk_q[2:0], i_cfg_bit};
   assign chk_want = CHECK_PATTERN | {3'b000, ld_par_q};
   assign frame_bad = (chk_seen != chk_want);

   // frame bit counting, parity and check shift
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         ld_bit_q <= {CNT_W{1'b0}};
         ld_chk_q <= 4'h0;
         ld_par_q <= 1'b0;
         o_cfg_error_n <= 1'b1;
         o_cfg_wait <= 1'b0;
      end else if (i_cfg_bit_valid && !o_cfg_wait && !i_cfg_done) begin
         if (ld_last) begin
            ld_bit_q <= {CNT_W{1'b0}};
            ld_par_q <= 1'b0;
            ld_chk_q <= 4'h0;
            if (frame_bad) begin
               o_cfg_error_n <= 1'b0;
               o_cfg_wait <= 1'b1;
            end
         end else begin
            ld_bit_q <= ld_bit_q + 1'b1;
            if (ld_in_check)
               ld_chk_q <= {ld_chk_q[2:0], i_cfg_bit};
            else if (ld_in_data)
               ld_par_q <= ld_par_q ^ i_cfg_bit;
         end
      end
   end

   // Position flags inside the current readback frame
   wire pos_start;
   wire pos_lead_ones;
   wire pos_check;
   wire pos_tail_ones;
   assign pos_start = (bit_q == {CNT_W{1'b0}});
   assign pos_lead_ones = (frame_q == {CNT_W{1'b0}}) &&
      (bit_q <= FIRST_ONES);
   assign pos_check = (bit_q >= CHK_START);
   assign pos_tail_ones = (frame_q == LAST_FRAME) &&
      (bit_q >= ONES_START);

   // Output bit selection per position
   always @* begin
      out_d = 1'b1;
      adv_crc = 1'b0;
      o_mem_rd = 1'b0;
      o_mem_frame = frame_q;
      o_mem_bit = bit_q;
      case (state_q)
         S_DUMMY: begin
            out_d = 1'b1;
         end
         S_FRAME: begin
            adv_crc = 1'b1;
            if (pos_start)
               out_d = 1'b0;
            else if (pos_lead_ones)
               out_d = 1'b1;
            else if (pos_check)
               out_d = 1'b1;
            else if (pos_tail_ones)
               out_d = 1'b1;
            else begin
               o_mem_rd = 1'b1;
               out_d = i_capture_en ? i_state_data : i_mem_data;
            end
         end
         S_END: begin
            out_d = 1'b0;
            adv_crc = 1'b1;
         end
         S_CRC: begin
            out_d = crc_q[15];
         end
         S_IDLE, S_FIN: begin
            // Idle level between readbacks
            out_d = 1'b1;
         end
         default: begin
            out_d = 1'b1;
         end
      endcase
   end

   // CRC feedback: top bit against the bit leaving on the net
   wire crc_fb;
   wire [15:0] crc_next;
   assign crc_fb = crc_q[15] ^ out_d;

   // Drained signature: plain shift, top bit leaves first
   wire [15:0] crc_drain;

   // one generator tap per CRC bit, MSB first
   genvar b;
   generate
      for (b = 0; b < 16; b = b + 1) begin : g_crc
         if (b == 0) begin : g_low
            assign crc_next[b] = crc_fb & CRC_POLY[b];
            assign crc_drain[b] = 1'b0;
         end else begin : g_up
            assign crc_next[b] = crc_q[b-1] ^ (crc_fb & CRC_POLY[b]);
            assign crc_drain[b] = crc_q[b-1];
         end
      end
   endgenerate

   // Sequencer step flags
   wire dummy_done;
   wire crc_done;
   wire frame_end;
   wire last_frame;

   // Counter end points
   assign dummy_done = (cnt_q == DUMMY_LAST);
   assign crc_done = (cnt_q == CRC_LAST);
   assign frame_end = (bit_q == LAST_BIT);
   assign last_frame = (frame_q == LAST_FRAME);

   // readback sequencer runs beside user logic
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         state_q <= S_IDLE;
         frame_q <= {CNT_W{1'b0}};
         bit_q <= {CNT_W{1'b0}};
         cnt_q <= 4'h0;
         crc_q <= `RB_CRC_SEED;
         o_read_in_progress <= 1'b0;
         o_readback_serial_out <= 1'b1;
      end else if (state_q == S_FIN && !trig_sync &&
                   !o_read_in_progress) begin
         // Rearm once the trigger drops, with no shift edge needed
         state_q <= S_IDLE;
      end else if (rise) begin
         case (state_q)
            S_IDLE: begin
               if (trig_sync && i_cfg_done && o_cfg_error_n) begin
                  o_read_in_progress <= 1'b1;
                  state_q <= S_DUMMY;
                  cnt_q <= 4'h0;
                  crc_q <= `RB_CRC_SEED;
               end
            end
            default: begin
               o_readback_serial_out <= out_d;
               if (adv_crc)
                  crc_q <= crc_next;
               else if (state_q == S_CRC)
                  crc_q <= crc_drain;
               case (state_q)
                  S_DUMMY: begin
                     cnt_q <= cnt_q + 1'b1;
                     if (dummy_done) begin
                        state_q <= S_FRAME;
                        frame_q <= {CNT_W{1'b0}};
                        bit_q <= {CNT_W{1'b0}};
                     end
                  end
                  S_FRAME: begin
                     if (frame_end) begin
                        bit_q <= {CNT_W{1'b0}};
                        if (last_frame)
                           state_q <= S_END;
                        else
                           frame_q <= frame_q + 1'b1;
                     end else begin
                        bit_q <= bit_q + 1'b1;
                     end
                  end
                  S_END: begin
                     state_q <= S_CRC;
                     cnt_q <= 4'h0;
                  end
                  S_CRC: begin
                     cnt_q <= cnt_q + 1'b1;
                     if (crc_done)
                        state_q <= S_FIN;
                  end
                  S_FIN: begin
                     o_read_in_progress <= 1'b0;
                     o_readback_serial_out <= 1'b1;
                     if (!trig_sync)
                        state_q <= S_IDLE;
                  end
                  default: begin
                     // Unused codes fall back to idle
                     o_read_in_progress <= 1'b0;
                     o_readback_serial_out <= 1'b1;
                     state_q <= S_IDLE;
                  end
               endcase
            end
         endcase
      end
   end
endmodule

// File: verification/readback_partner.sv
// Far-side model driving trigger and shift clock
`timescale 1ns/1ns
module readback_partner(input wire i_clk, input wire i_rip,
   input wire i_dat, output logic o_trig, output logic o_sclk);
   logic got [1:49];
   logic rp [1:49];
   integer k;
   initial begin
      o_trig = 0;
      o_sclk = 0;
   end
   // trigger, then 49 shift edges of 800 ns
   task run; begin
      @(negedge i_clk) o_trig = 1;
      repeat (4) @(negedge i_clk);
      for (k = 1; k <= 49; k = k + 1) begin
         o_sclk = 1;
         repeat (4) @(negedge i_clk);
         o_sclk = 0;
         repeat (4) @(negedge i_clk);
         got[k] = i_dat;
         rp[k] = i_rip;
      end
      o_trig = 0;
      repeat (4) @(negedge i_clk);
   end endtask
endmodule

// File: verification/config_readback_crc_serializer_props.sv
// Port checks for the readback serializer
`timescale 1ns/1ns
module readback_props(input wire i_clk, input wire i_resetn,
   input wire i_cfg_done, input wire o_cfg_error_n, input wire o_cfg_wait,
   input wire i_readback_shift_clock, input wire o_read_in_progress,
   input wire o_readback_serial_out);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   chk_wait_on_err: assert property (
      $fell(o_cfg_error_n) |-> ##[0:1] o_cfg_wait) else $error("no wait");
   chk_wait_sticky: assert property (
      o_cfg_wait |=> o_cfg_wait && !o_cfg_error_n) else $error("wait lost");
   chk_no_rb_err: assert property (
      !o_cfg_error_n |-> !o_read_in_progress) else $error("rb after err");
   chk_rb_needs_done: assert property (
      $rose(o_read_in_progress) |-> i_cfg_done) else $error("rb early");
   chk_rb_idle_high: assert property (
      $rose(o_read_in_progress) |-> o_readback_serial_out)
      else $error("start low");
   chk_out_holds: assert property (
      $stable(i_readback_shift_clock)[*6] |-> $stable(o_readback_serial_out))
      else $error("data moved");
   chk_flag_holds: assert property (
      $stable(i_readback_shift_clock)[*6] |-> $stable(o_read_in_progress))
      else $error("flag moved");
   chk_end_high: assert property (
      $fell(o_read_in_progress) |-> o_readback_serial_out)
      else $error("end low");
endmodule
bind config_readback_crc_serializer readback_props readback_props_inst(
   .i_clk, .i_resetn, .i_cfg_done, .o_cfg_error_n, .o_cfg_wait,
   .i_readback_shift_clock, .o_read_in_progress, .o_readback_serial_out);

// File: verification/config_readback_crc_serializer_bench.sv
// Self-checking bench for the readback serializer
`timescale 1ns/1ns
`include "readback_defines.vh"
module config_readback_crc_serializer_bench;
   localparam FB = 10;
   localparam NF = 3;
   logic clk = 0, rst_n = 0, vld = 0, cbit = 0, done = 0, mem;
   logic cap = 0, st = 0, e;
   logic [15:0] crc;
   wire err_n, cwait, mrd, rip, dout, trig, sclk;
   wire [15:0] mfr, mbit;
   integer err_total = 0, num_checks = 0, i, f;
   always #50 clk = ~clk;
   // Memory model: each stored bit equals the low bit of its bit address
   always @* mem = mbit[0];
   config_readback_crc_serializer #(.FRAME_BITS(FB), .NUM_FRAMES(NF))
   config_readback_crc_serializer_inst(.i_clk(clk), .i_resetn(rst_n),
      .i_cfg_bit_valid(vld), .i_cfg_bit(cbit), .i_cfg_done(done),
      .o_cfg_error_n(err_n), .o_cfg_wait(cwait), .o_mem_rd(mrd),
      .o_mem_frame(mfr), .o_mem_bit(mbit), .i_mem_data(mem),
      .i_capture_en(cap), .i_state_data(st), .i_readback_trigger(trig),
      .i_readback_shift_clock(sclk), .o_read_in_progress(rip),
      .o_readback_serial_out(dout));
   readback_partner readback_partner_inst(.i_clk(clk), .i_rip(rip),
      .i_dat(dout), .o_trig(trig), .o_sclk(sclk));
   task chk(input string n, input logic x, input logic y); begin
      num_checks = num_checks + 1;
      if (x !== y) begin
         err_total = err_total + 1;
         $display("wrong value %s expected %b seen %b", n, x, y);
      end
   end endtask
   // Frames: start 0, zero data, check bits 1 0 1 p
   task load(input logic bad); begin
      for (i = 0; i < NF * FB; i = i + 1) begin
         @(negedge clk) vld = 1;
         f = i % FB;
         cbit = (f == FB - 4 || f == FB - 2) ^ (bad && i == 2 * FB - 3);
      end
      @(negedge clk) vld = 0;
      repeat (3) @(negedge clk);
   end endtask
   task readback(input logic v); begin
      crc = `RB_CRC_SEED;
      readback_partner_inst.run;
      chk("rip_rise", 1, readback_partner_inst.rp[1]);
      for (i = 2; i <= 48; i = i + 1) begin
         f = (i - 7) % FB;
         if (i < 7 || (i < 37 && f >= FB - 4)) e = 1;
         else if (i > 37) e = crc[53 - i];
         else if (i == 37 || f == 0) e = 0;
         else if (i < 7 + FB && f <= 2) e = 1;
         else if (i >= 37 - 7) e = 1;
         else e = v ? 1'b1 : f[0];
         if (i >= 7 && i <= 37)
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ e) ? `RB_CRC_POLY : 16'h0000);
         chk("data_bit", e, readback_partner_inst.got[i]);
      end
      chk("rip_crc", 1, readback_partner_inst.rp[48]);
      chk("rip_end", 0, readback_partner_inst.rp[49]);
      chk("end_level", 1, readback_partner_inst.got[49]);
      chk("mem_rd_idle", 0, mrd);
   end endtask
   task t_abort; begin
      load(1);
      chk("error_pin", 0, err_n);
      chk("wait_state", 1, cwait);
      @(negedge clk) done = 1;
      readback_partner_inst.run;
      chk("rip_refused", 0, readback_partner_inst.rp[1]);
      $display("abort test end");
   end endtask
   task t_readback; begin
      load(0);
      chk("error_pin", 1, err_n);
      @(negedge clk) done = 1;
      readback(0);
      @(negedge clk) cap = 1;
      st = 1;
      readback(1);
      $display("readback test end");
   end endtask
   task results; begin
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end endtask
   // Three runs of about 400 cycles plus loads, with margin
   initial begin
      #1000000;
      err_total = err_total + 1;
      results;
   end
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1;
      chk("idle_out", 1, dout);
      t_abort;
      rst_n = 0;
      repeat (20) @(negedge clk);
      done = 0;
      rst_n = 1;
      t_readback;
      results;
   end
endmodule
